// ==== hw/cdcm_params.svh ====
// constants of the coupler diagnostic and cycle monitor
`ifndef CDCM_PARAMS_SVH
`define CDCM_PARAMS_SVH
`define CDCM_CLK_PERIOD_NS 25
`define CDCM_US_NS         1000
`define CDCM_CYC_PER_US    (`CDCM_US_NS / `CDCM_CLK_PERIOD_NS)
`define CDCM_BLINK_HALF_MS 250
`define CDCM_CYC_BLINK     ((`CDCM_BLINK_HALF_MS * 1000000) / `CDCM_CLK_PERIOD_NS)
`define CDCM_ADDR_W        12
`define CDCM_IDX_MSB       11
`define CDCM_IDX_LSB       4
`define CDCM_BYTE_MSB      3
`define CDCM_IDX_STATUS    8'h5a
`define CDCM_IDX_STATS     8'h62
`define CDCM_IDX_CYCCMD    8'h63
`define CDCM_CMD_B0        8'h04
`define CDCM_CMD_B1        8'h01
`define CDCM_CMD_START_B2  8'h01
`define CDCM_CMD_STOP_B2   8'h00
`define CDCM_CMD_B3        8'h00
`define CDCM_CMD_LAST_BYTE 4'h3
`define CDCM_MEAN_WINDOW   8'hc8
`define CDCM_BIT_FIELDBUS  0
`define CDCM_BIT_KBUS      1
`define CDCM_BIT_TERMINAL  2
`define CDCM_BIT_COUPLER   3
`define CDCM_US_MAX        16'hffff
`endif

// ==== hw/cdcm_pkg.sv ====
// types of the coupler diagnostic and cycle monitor
package cdcm_pkg;
   typedef enum logic [2:0] {
      CDCM_NO_ACTIVITY,
      CDCM_NOT_STARTED,
      CDCM_RUN,
      CDCM_PARAM_ACTIVE,
      CDCM_ERR_KEEP,
      CDCM_ERR_STOP
   } cdcm_comm_t;
   typedef enum logic {
      CDCM_DIV_IDLE,
      CDCM_DIV_RUN
   } cdcm_div_t;
endpackage

// ==== hw/cdcm_top.sv ====
// coupler diagnostic record, cycle-time monitor and fieldbus indicators
//
// Our own choices: the address map and the strobed register port.
`include "cdcm_params.svh"
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cdcm_top
   import cdcm_pkg::*;
#(
   parameter int BLINK_HALF_CYCLES = `CDCM_CYC_BLINK
)(
   input  wire logic                    clock_i,
   input  wire logic                    resetn_i,
   input  wire logic [`CDCM_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]              wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [7:0]              rdata_o,
   input  wire logic                    fieldbus_err_i,
   input  wire logic                    kbus_err_i,
   input  wire logic                    terminal_err_i,
   input  wire logic                    coupler_err_i,
   input  wire logic [15:0]             coupler_code_i,
   input  wire logic [15:0]             kbus_bit_len_i,
   input  wire logic [15:0]             kbus_code_i,
   input  wire logic [15:0]             term_count_i,
   input  wire logic [15:0]             err_term_i,
   input  wire logic                    cycle_start_i,
   input  wire cdcm_comm_t              comm_state_i,
   output logic                         meas_on_o,
   output logic                         run_indicator_o,
   output logic                         bus_fault_indicator_o,
   output logic                         diagnostic_indicator_o
);

   function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                            input logic        hi);
      pick_byte = hi ? w[15:8] : w[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic [7:0] idx;
   logic [3:0] bsel;
   logic       stat_clr;
   logic       cmd_last;
   logic       start_hit;
   logic       stop_hit;
   logic [7:0] cmd_b_reg [0:2];

   assign idx      = addr_i[`CDCM_IDX_MSB:`CDCM_IDX_LSB];
   assign bsel     = addr_i[`CDCM_BYTE_MSB:0];
   assign stat_clr = wr_i && idx == `CDCM_IDX_STATS;
   assign cmd_last = wr_i && idx == `CDCM_IDX_CYCCMD
                     && bsel == `CDCM_CMD_LAST_BYTE;
   assign start_hit = cmd_last && cmd_b_reg[0] == `CDCM_CMD_B0
                      && cmd_b_reg[1] == `CDCM_CMD_B1
                      && cmd_b_reg[2] == `CDCM_CMD_START_B2
                      && wdata_i == `CDCM_CMD_B3;
   assign stop_hit  = cmd_last && cmd_b_reg[0] == `CDCM_CMD_B0
                      && cmd_b_reg[1] == `CDCM_CMD_B1
                      && cmd_b_reg[2] == `CDCM_CMD_STOP_B2
                      && wdata_i == `CDCM_CMD_B3;

   // command bytes 0..2 collected, byte 3 completes the command
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < 3; i++)
            cmd_b_reg[i] <= 8'h00;
      end
      else if (wr_i && idx == `CDCM_IDX_CYCCMD && bsel < `CDCM_CMD_LAST_BYTE)
         cmd_b_reg[bsel[1:0]] <= wdata_i;
   end

   logic meas_on_reg;
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         meas_on_reg <= 1'b0;
      else if (start_hit)
         meas_on_reg <= 1'b1;
      else if (stop_hit)
         meas_on_reg <= 1'b0;
   end
   assign meas_on_o = meas_on_reg;

   ////////////////////////////////////////////////////////////////////////////
   // microsecond timer between cycle starts
   logic [5:0]  us_div_reg;
   logic [15:0] us_count_reg;
   logic        have_prev_reg;
   logic        sample;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         us_div_reg   <= 6'h00;
         us_count_reg <= 16'h0000;
      end
      else if (cycle_start_i)
      begin
         // start edge is the first clock of the new interval
         us_div_reg   <= 6'h01;
         us_count_reg <= 16'h0000;
      end
      else if (us_div_reg == 6'(`CDCM_CYC_PER_US - 1))
      begin
         us_div_reg <= 6'h00;
         if (us_count_reg != `CDCM_US_MAX)
            us_count_reg <= us_count_reg + 16'h0001;
      end
      else
         us_div_reg <= us_div_reg + 6'h01;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || start_hit)
         have_prev_reg <= 1'b0;
      else if (cycle_start_i && meas_on_reg)
         have_prev_reg <= 1'b1;
   end
   assign sample = meas_on_reg && cycle_start_i && have_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // statistics
   logic [15:0] min_reg;
   logic [15:0] max_reg;
   logic [15:0] cur_reg;
   logic [15:0] mean_reg;
   logic        seeded_reg;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || stat_clr)
      begin
         min_reg    <= 16'h0000;
         max_reg    <= 16'h0000;
         cur_reg    <= 16'h0000;
         seeded_reg <= 1'b0;
      end
      else if (sample)
      begin
         cur_reg    <= us_count_reg;
         seeded_reg <= 1'b1;
         if (!seeded_reg || us_count_reg < min_reg)
            min_reg <= us_count_reg;
         if (!seeded_reg || us_count_reg > max_reg)
            max_reg <= us_count_reg;
      end
   end

   // sliding window of the latest cycle times
   logic [15:0] hist_reg [0:199];
   logic [7:0]  ptr_reg;
   logic [7:0]  fill_reg;
   logic [23:0] sum_reg;
   logic [23:0] sum_next;
   logic [7:0]  fill_next;
   logic        full;

   assign full      = fill_reg == `CDCM_MEAN_WINDOW;
   assign sum_next  = sum_reg + {8'h00, us_count_reg}
                      - (full ? {8'h00, hist_reg[ptr_reg]} : 24'h000000);
   assign fill_next = full ? fill_reg : fill_reg + 8'h01;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || stat_clr)
      begin
         ptr_reg  <= 8'h00;
         fill_reg <= 8'h00;
         sum_reg  <= 24'h000000;
      end
      else if (sample)
      begin
         sum_reg  <= sum_next;
         fill_reg <= fill_next;
         ptr_reg  <= (ptr_reg == `CDCM_MEAN_WINDOW - 8'h01) ? 8'h00
                     : ptr_reg + 8'h01;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sample)
         hist_reg[ptr_reg] <= us_count_reg;
   end

   // sequential divider: mean = window sum / window fill
   cdcm_div_t   div_state;
   logic [23:0] quot_reg;
   logic [7:0]  rem_reg;
   logic [7:0]  dvs_reg;
   logic [4:0]  dcnt_reg;
   logic [8:0]  trial;

   assign trial = {rem_reg, quot_reg[23]};

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || stat_clr)
      begin
         div_state <= CDCM_DIV_IDLE;
         quot_reg  <= 24'h000000;
         rem_reg   <= 8'h00;
         dvs_reg   <= 8'h01;
         dcnt_reg  <= 5'h00;
         mean_reg  <= 16'h0000;
      end
      else if (sample)
      begin
         div_state <= CDCM_DIV_RUN;
         quot_reg  <= sum_next;
         rem_reg   <= 8'h00;
         dvs_reg   <= fill_next;
         dcnt_reg  <= 5'h00;
      end
      else
      begin
         case (div_state)
            CDCM_DIV_RUN:
            begin
               if (trial >= {1'b0, dvs_reg})
               begin
                  rem_reg  <= 8'(trial - {1'b0, dvs_reg});
                  quot_reg <= {quot_reg[22:0], 1'b1};
               end
               else
               begin
                  rem_reg  <= trial[7:0];
                  quot_reg <= {quot_reg[22:0], 1'b0};
               end
               dcnt_reg <= dcnt_reg + 5'h01;
               if (dcnt_reg == 5'd23)
                  div_state <= CDCM_DIV_IDLE;
            end
            CDCM_DIV_IDLE:
               mean_reg <= quot_reg[15:0];
            default:
               div_state <= CDCM_DIV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // record read port
   logic [15:0] st_word [0:3];
   logic [15:0] cy_word [0:3];

   assign st_word[0] = {12'h000, coupler_err_i, terminal_err_i,
                        kbus_err_i, fieldbus_err_i};
   assign st_word[1] = coupler_err_i ? coupler_code_i : 16'h0000;
   assign st_word[2] = kbus_err_i ? kbus_code_i : kbus_bit_len_i;
   assign st_word[3] = kbus_err_i ? err_term_i : term_count_i;
   assign cy_word[0] = min_reg;
   assign cy_word[1] = max_reg;
   assign cy_word[2] = mean_reg;
   assign cy_word[3] = cur_reg;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         rdata_o <= 8'h00;
      else if (rd_i && bsel[3] == 1'b0)
      begin
         if (idx == `CDCM_IDX_STATUS)
            rdata_o <= pick_byte(st_word[bsel[2:1]], bsel[0]);
         else if (idx == `CDCM_IDX_STATS)
            rdata_o <= pick_byte(cy_word[bsel[2:1]], bsel[0]);
         else
            rdata_o <= 8'h00;
      end
      else
         rdata_o <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // fieldbus indicators
   logic [23:0] blink_cnt_reg;
   logic        blink_reg;

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         blink_cnt_reg <= 24'h000000;
         blink_reg     <= 1'b0;
      end
      else if (blink_cnt_reg >= 24'(BLINK_HALF_CYCLES - 1))
      begin
         blink_cnt_reg <= 24'h000000;
         blink_reg     <= ~blink_reg;
      end
      else
         blink_cnt_reg <= blink_cnt_reg + 24'h000001;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         run_indicator_o        <= 1'b0;
         bus_fault_indicator_o  <= 1'b0;
         diagnostic_indicator_o <= 1'b0;
      end
      else
      begin
         case (comm_state_i)
            CDCM_RUN:
            begin
               run_indicator_o        <= 1'b1;
               bus_fault_indicator_o  <= 1'b0;
               diagnostic_indicator_o <= 1'b0;
            end
            CDCM_PARAM_ACTIVE, CDCM_ERR_KEEP:
            begin
               run_indicator_o        <= 1'b1;
               bus_fault_indicator_o  <= 1'b1;
               diagnostic_indicator_o <= blink_reg;
            end
            CDCM_NO_ACTIVITY:
            begin
               run_indicator_o        <= 1'b0;
               bus_fault_indicator_o  <= 1'b1;
               diagnostic_indicator_o <= 1'b1;
            end
            CDCM_ERR_STOP:
            begin
               run_indicator_o        <= 1'b0;
               bus_fault_indicator_o  <= 1'b1;
               diagnostic_indicator_o <= blink_reg;
            end
            default:
            begin
               run_indicator_o        <= 1'b0;
               bus_fault_indicator_o  <= 1'b0;
               diagnostic_indicator_o <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   a_start_cmd_on: assert property (start_hit |=> meas_on_reg)
      else $error("start command did not enable measurement");
   a_stop_cmd_off: assert property (stop_hit && !start_hit |=> !meas_on_reg)
      else $error("stop command did not halt measurement");
   a_stats_clear: assert property (stat_clr |=> min_reg == 16'h0000
      && max_reg == 16'h0000 && cur_reg == 16'h0000
      && mean_reg == 16'h0000 && !seeded_reg)
      else $error("statistics not cleared by write");
   a_stopped_hold: assert property (!meas_on_reg && !stat_clr |=>
      $stable(min_reg) && $stable(max_reg) && $stable(cur_reg))
      else $error("statistics changed while stopped");
   a_window_bound: assert property (fill_reg <= `CDCM_MEAN_WINDOW)
      else $error("mean window exceeds its length");
   a_min_max_order: assert property (seeded_reg |-> min_reg <= max_reg)
      else $error("minimum above maximum");
   a_status_flags: assert property (rd_i && idx == `CDCM_IDX_STATUS
      && bsel == 4'h0 |=> rdata_o == {4'h0, $past(coupler_err_i),
      $past(terminal_err_i), $past(kbus_err_i), $past(fieldbus_err_i)})
      else $error("status flag byte wrong");
   a_bitlen_low: assert property (rd_i && idx == `CDCM_IDX_STATUS
      && bsel == 4'h4 && !kbus_err_i |=>
      rdata_o == $past(kbus_bit_len_i[7:0]))
      else $error("bit length byte wrong");
   a_led_run: assert property (comm_state_i == CDCM_RUN |=> run_indicator_o
      && !bus_fault_indicator_o && !diagnostic_indicator_o)
      else $error("run indicators wrong");
   a_led_idle: assert property (comm_state_i == CDCM_NOT_STARTED |=>
      !run_indicator_o && !bus_fault_indicator_o
      && !diagnostic_indicator_o)
      else $error("idle indicators wrong");
   a_led_nobus: assert property (comm_state_i == CDCM_NO_ACTIVITY |=>
      !run_indicator_o && bus_fault_indicator_o
      && diagnostic_indicator_o)
      else $error("no-activity indicators wrong");

   c_start: cover property (start_hit ##1 sample);
   c_full_window: cover property (full && sample);
   c_clear_running: cover property (meas_on_reg && stat_clr);
   c_err_stop: cover property (comm_state_i == CDCM_ERR_STOP);

endmodule
`default_nettype wire

// ==== bench/cdcm_master_model.sv ====
// fieldbus master model issuing record reads and writes on slot 0
`include "cdcm_params.svh"
`timescale 1ns/100ps
`default_nettype none
module cdcm_master_model (
   input  wire logic        clock_i,
   input  wire logic [7:0]  rdata_i,
   output logic      [11:0] addr_o,
   output logic      [7:0]  wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   logic [7:0] cap;
   initial
   begin
      addr_o = 12'h000;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // read byte stands only in the cycle after the strobe
   always @(negedge clock_i) cap <= rdata_i;
   // released address and data lines show the inverse, not the last value
   task automatic wr_rec(input logic [7:0] idx, input logic [31:0] d);
      for (int i = 0; i < 4; i++)
      begin
         wr_o <= 1'b1;
         addr_o <= {idx, 4'(i)};
         wdata_o <= d[8*i+:8];
         @(posedge clock_i);
      end
      wr_o <= 1'b0;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
      @(posedge clock_i);
   endtask
   task automatic rd_rec(input logic [7:0] idx, input logic [3:0] base,
                         output logic [63:0] v);
      for (int i = 0; i <= 8; i++)
      begin
         if (i < 8)
         begin
            rd_o <= 1'b1;
            addr_o <= {idx, base + 4'(i)};
         end
         else
         begin
            rd_o <= 1'b0;
            addr_o <= ~addr_o;
         end
         @(posedge clock_i);
         if (i > 0)
            v[8*(i-1)+:8] = cap;
      end
   endtask
   task automatic meas_cmd(input logic go);
      wr_rec(`CDCM_IDX_CYCCMD, {`CDCM_CMD_B3,
             (go ? `CDCM_CMD_START_B2 : `CDCM_CMD_STOP_B2),
             `CDCM_CMD_B1, `CDCM_CMD_B0});
   endtask
endmodule
`default_nettype wire

// ==== bench/coupler_diag_cycle_monitor_bench.sv ====
// self-checking bench of status record, cycle monitor and indicators
`include "cdcm_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
      end \
   end
module coupler_diag_cycle_monitor_bench
   import cdcm_pkg::*;
;
   logic        clock_i, resetn_i, wr, rd, cyc, meas, run_l, bf_l, dia_l;
   logic        ferr, kerr, terr, cerr, hi, lo;
   logic [11:0] addr;
   logic [7:0]  wdata, rdata;
   logic [15:0] ccode, blen, kcode, tcnt, eterm;
   logic [63:0] v, ev;
   cdcm_comm_t  comm;
   int          mismatches = 0;
   int          n_tests = 0;
   int          seed = 78;
   int          gv, mn, mx, sm;
   cdcm_top #(.BLINK_HALF_CYCLES(4)) u_dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .fieldbus_err_i(ferr), .kbus_err_i(kerr), .terminal_err_i(terr),
      .coupler_err_i(cerr), .coupler_code_i(ccode), .kbus_bit_len_i(blen),
      .kbus_code_i(kcode), .term_count_i(tcnt), .err_term_i(eterm),
      .cycle_start_i(cyc), .comm_state_i(comm), .meas_on_o(meas),
      .run_indicator_o(run_l), .bus_fault_indicator_o(bf_l),
      .diagnostic_indicator_o(dia_l));
   cdcm_master_model u_master (
      .clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [63:0] exp_stat();
      return {kerr ? eterm : tcnt, kerr ? kcode : blen,
              cerr ? ccode : 16'h0000, 8'h00, {4'h0, cerr, terr, kerr, ferr}};
   endfunction
   // run, fault, diagnostic seen high, diagnostic seen low
   function automatic logic [3:0] exp_led(input int s);
      case (s)
         0: return 4'h6;
         2: return 4'h9;
         3, 4: return 4'hf;
         5: return 4'h7;
         default: return 4'h1;
      endcase
   endfunction
   task automatic gap(input int us);
      repeat (`CDCM_CYC_PER_US * us - 1) @(posedge clock_i);
      cyc <= 1'b1;
      @(posedge clock_i);
      cyc <= 1'b0;
   endtask
   task automatic finish_test();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   initial
   begin
      repeat (60000) @(posedge clock_i);
      mismatches++;
      finish_test();
   end
   initial
   begin
      resetn_i = 1'b0;
      {ferr, kerr, terr, cerr} = 4'h0;
      {ccode, blen, kcode, tcnt, eterm} = 80'h0;
      cyc = 1'b0;
      comm = CDCM_NOT_STARTED;
      repeat (6) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(negedge clock_i);
      `CHK({rdata, meas, run_l, bf_l, dia_l}, 12'h000)
      @(posedge clock_i);
      for (int i = 0; i < 8; i++)
      begin
         {ferr, kerr, terr, cerr} <= (i == 0) ? 4'h0 :
                                     (i == 1) ? 4'hf : 4'($random(seed));
         {ccode, blen, kcode, tcnt, eterm} <=
            {$random(seed), $random(seed), 16'($random(seed))};
         u_master.rd_rec(`CDCM_IDX_STATUS, 4'h0, v);
         `CHK(v, exp_stat())
      end
      u_master.rd_rec(8'h00, 4'h0, v);
      `CHK(v, 64'h0)
      u_master.rd_rec(`CDCM_IDX_STATUS, 4'h8, v);
      `CHK(v, 64'h0)
      // near-miss command pattern must not start anything
      u_master.wr_rec(`CDCM_IDX_CYCCMD, 32'h00020104);
      @(negedge clock_i);
      `CHK(meas, 1'b0)
      @(posedge clock_i);
      u_master.meas_cmd(1'b1);
      @(negedge clock_i);
      `CHK(meas, 1'b1)
      @(posedge clock_i);
      gap(1);
      mn = 9999;
      mx = 0;
      sm = 0;
      for (int i = 0; i < 4; i++)
      begin
         gv = 1 + {$random(seed)} % 8;
         gap(gv);
         mn = (gv < mn) ? gv : mn;
         mx = (gv > mx) ? gv : mx;
         sm += gv;
      end
      repeat (40) @(posedge clock_i);
      ev = {16'(gv), 16'(sm / 4), 16'(mx), 16'(mn)};
      u_master.rd_rec(`CDCM_IDX_STATS, 4'h0, v);
      `CHK(v, ev)
      u_master.meas_cmd(1'b0);
      @(negedge clock_i);
      `CHK(meas, 1'b0)
      @(posedge clock_i);
      gap(3);
      gap(5);
      repeat (40) @(posedge clock_i);
      u_master.rd_rec(`CDCM_IDX_STATS, 4'h0, v);
      `CHK(v, ev)
      u_master.wr_rec(`CDCM_IDX_STATS, 32'h0);
      u_master.rd_rec(`CDCM_IDX_STATS, 4'h0, v);
      `CHK(v, 64'h0)
      // long samples fall out of the 200-sample mean window
      u_master.meas_cmd(1'b1);
      gap(1);
      repeat (10) gap(9);
      repeat (200) gap(2);
      repeat (40) @(posedge clock_i);
      u_master.rd_rec(`CDCM_IDX_STATS, 4'h0, v);
      `CHK(v, 64'h0002000200090002)
      for (int s = 0; s < 8; s++)
      begin
         comm <= cdcm_comm_t'(3'(s));
         repeat (3) @(posedge clock_i);
         hi = 1'b0;
         lo = 1'b0;
         repeat (12)
         begin
            @(negedge clock_i);
            hi = hi | dia_l;
            lo = lo | !dia_l;
         end
         `CHK({run_l, bf_l, hi, lo}, exp_led(s))
         @(posedge clock_i);
      end
      finish_test();
   end
endmodule
`default_nettype wire
